// ===== lane_power_pkg.sv
package lane_power_pkg;

    // ------------------------------------------------------------------
    // configuration port, lane count and field widths
    // ------------------------------------------------------------------
    localparam int          ADDR_WIDTH = 12;
    localparam int          DATA_WIDTH = 8;
    localparam int          LANE_COUNT = 8;
    localparam int          TEST_WIDTH = 5;
    localparam int          MODE_WIDTH = 5;

    // ------------------------------------------------------------------
    // register offsets and reset values
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CHANNEL_POWER_DOWN       = 12'h209;
    localparam logic [11:0] ADDR_EXTRA_LANE_ENABLE_LINK_A = 12'h20A;
    localparam logic [11:0] ADDR_EXTRA_LANE_ENABLE_LINK_B = 12'h20B;
    localparam logic [7:0]  RESET_CHANNEL_POWER_DOWN      = 8'h00;
    localparam logic [7:0]  RESET_EXTRA_LANE_ENABLE       = 8'h00;
    localparam logic [7:0]  READ_UNMAPPED                 = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          FIRST_CHANNEL_OFF_BIT  = 0;
    localparam int          SECOND_CHANNEL_OFF_BIT = 1;
    localparam int          EXTRA_SERIALIZER_BIT   = 0;
    localparam int          BIND_FIRST_FROM_SECOND = 0;
    localparam int          BIND_SECOND_FROM_FIRST = 1;

    // ------------------------------------------------------------------
    // test pattern codes
    // ------------------------------------------------------------------
    localparam logic [4:0]  TEST_PATTERN_NONE       = 5'h00;
    localparam logic [4:0]  TEST_PATTERN_RAMP       = 5'h04;
    localparam logic [4:0]  TEST_PATTERN_RAMP_AS_NONE = 5'h05;

endpackage : lane_power_pkg

// ===== lane_ctrl_if.sv
`timescale 1ns/1ps
`default_nettype none

interface lane_ctrl_if;
    logic [7:0] extra_lane_reg;
    logic [7:0] mode_lanes;
    logic       link_on;
    logic [4:0] test_pattern;
    logic [7:0] lane_clk_en;
    logic [7:0] ser_clk_en;
    logic [7:0] lane_ramp;

    modport ctrl (
        output extra_lane_reg,
        output mode_lanes,
        output link_on,
        output test_pattern,
        input  lane_clk_en,
        input  ser_clk_en,
        input  lane_ramp
    );

    modport lanes (
        input  extra_lane_reg,
        input  mode_lanes,
        input  link_on,
        input  test_pattern,
        output lane_clk_en,
        output ser_clk_en,
        output lane_ramp
    );
endinterface : lane_ctrl_if

`default_nettype wire

// ===== lane_enable_logic.sv
`timescale 1ns/1ps
`default_nettype none

module lane_enable_logic (
    lane_ctrl_if.lanes link
);
    logic       ser_on;
    logic       ramp_pattern;
    logic [7:0] extra_req;
    logic [7:0] ser_req;
    logic [7:0] ser_chain;

    assign ser_on       = link.extra_lane_reg[lane_power_pkg::EXTRA_SERIALIZER_BIT];
    assign ramp_pattern = (link.test_pattern == lane_power_pkg::TEST_PATTERN_NONE) ||
                          (link.test_pattern == lane_power_pkg::TEST_PATTERN_RAMP_AS_NONE);

    // ------------------------------------------------------------------
    // per lane enables; lane 0 is never an extra lane
    // ------------------------------------------------------------------
    genvar n;
    generate
        for (n = 0; n < lane_power_pkg::LANE_COUNT; n++) begin : g_lane
            if (n == 0) begin : g_base
                assign extra_req[n] = 1'b0;
            end else begin : g_extra
                assign extra_req[n] = link.extra_lane_reg[n];
            end
            // clocks follow the extra bit even for lanes the mode leaves idle
            assign link.lane_clk_en[n] = link.link_on &
                                         (link.mode_lanes[n] | extra_req[n]); // [RULE9] [RULE14]
            assign ser_req[n]          = link.link_on &
                                         (link.mode_lanes[n] | (extra_req[n] & ser_on)); // [RULE10] [RULE14]
            if (n == 0) begin : g_chain0
                assign ser_chain[n] = ser_req[n];
            end else begin : g_chainn
                assign ser_chain[n] = ser_req[n] & ser_chain[n-1]; // [RULE15]
            end
            assign link.ser_clk_en[n] = ser_chain[n];
            // extra-only lanes replace no-pattern codes by the octet ramp
            assign link.lane_ramp[n]  = link.lane_clk_en[n] & extra_req[n] &
                                        ~link.mode_lanes[n] & ramp_pattern; // [RULE13]
        end
    endgenerate
endmodule : lane_enable_logic

`default_nettype wire

// ===== channel_power_logic.sv
`timescale 1ns/1ps
`default_nettype none

module channel_power_logic (
    input  wire logic       first_channel_off,
    input  wire logic       second_channel_off,
    input  wire logic [1:0] digital_channel_binding,
    input  wire logic       mode_both_on_link_a,
    input  wire logic       serial_link_enable,
    output logic            digital_first_off,
    output logic            digital_second_off,
    output logic            subsystem_off,
    output logic            link_a_on,
    output logic            link_b_on,
    output logic            second_slots_undefined
);
    logic first_src_off;
    logic second_src_off;

    // digital channels follow whichever converter they are bound to
    assign first_src_off  = digital_channel_binding[lane_power_pkg::BIND_FIRST_FROM_SECOND]
                            ? second_channel_off : first_channel_off;
    assign second_src_off = digital_channel_binding[lane_power_pkg::BIND_SECOND_FROM_FIRST]
                            ? first_channel_off : second_channel_off;

    assign digital_first_off  = first_src_off; // [RULE3]
    assign digital_second_off = second_src_off; // [RULE3]
    assign subsystem_off      = first_channel_off & second_channel_off; // [RULE6]

    // a shared link survives loss of the second digital channel
    assign link_a_on = serial_link_enable & ~subsystem_off &
                       (~digital_first_off | mode_both_on_link_a); // [RULE7]
    assign link_b_on = serial_link_enable & ~subsystem_off & ~digital_second_off;
    assign second_slots_undefined = link_a_on & mode_both_on_link_a &
                                    digital_second_off; // [RULE7]
endmodule : channel_power_logic

`default_nettype wire

// ===== lane_channel_power_control.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (RULE1) bit 1 powers down second converter
// (RULE2) bit 0 powers down first converter
// (RULE3) bound digital channels follow converter power-down
// (RULE4) software clears link enable before changing power-down
// (RULE5) software uses mode register for both off
// (RULE6) both converters off kills serial subsystem
// (RULE7) shared link keeps running, second slots undefined
// (RULE8) software sets calibration converter-off field 0x1
// (RULE9) link A bits 7:1 enable lane clocks
// (RULE10) bit 0 adds serializers to extra lanes
// (RULE11) software changes extra lanes only link disabled
// (RULE12) extra lanes follow link mode and pattern
// (RULE13) extra-only lane sends ramp for patterns 0,5
// (RULE14) power-down overrides extra lane enables
// (RULE15) serializer n needs lanes 0..n-1 enabled
// (RULE16) link B extra lanes mirror link A

module lane_channel_power_control (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // configuration port
    input  wire logic [11:0] cfg_addr,
    input  wire logic [7:0]  cfg_wdata,
    input  wire logic        cfg_write,
    input  wire logic        cfg_read,
    output logic      [7:0]  cfg_rdata,
    output logic             cfg_rvalid,
    // settings held elsewhere in the device
    input  wire logic        serial_link_enable,
    input  wire logic [4:0]  link_mode_select,
    input  wire logic [4:0]  test_pattern_select,
    input  wire logic [1:0]  digital_channel_binding,
    input  wire logic        mode_both_on_link_a,
    input  wire logic [7:0]  mode_lanes_link_a,
    input  wire logic [7:0]  mode_lanes_link_b,
    // power controls
    output logic             first_channel_off,
    output logic             second_channel_off,
    output logic             digital_first_off,
    output logic             digital_second_off,
    output logic             serial_subsystem_off,
    output logic             link_a_active,
    output logic             link_b_active,
    output logic             second_slots_undefined,
    // lane controls
    output logic      [7:0]  link_a_lane_clk_en,
    output logic      [7:0]  link_a_ser_clk_en,
    output logic      [7:0]  link_a_lane_ramp,
    output logic      [7:0]  link_b_lane_clk_en,
    output logic      [7:0]  link_b_ser_clk_en,
    output logic      [7:0]  link_b_lane_ramp,
    output logic      [4:0]  lane_mode,
    output logic      [4:0]  lane_test_pattern
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] channel_power_down;
        logic [7:0] extra_lane_enable_link_a;
        logic [7:0] extra_lane_enable_link_b;
        logic [7:0] rdata;
        logic       rvalid;
        logic       first_off;
        logic       second_off;
        logic       dig_first_off;
        logic       dig_second_off;
        logic       subsystem_off;
        logic       link_a_on;
        logic       link_b_on;
        logic       slots_undefined;
        logic [7:0] a_lane_clk;
        logic [7:0] a_ser_clk;
        logic [7:0] a_ramp;
        logic [7:0] b_lane_clk;
        logic [7:0] b_ser_clk;
        logic [7:0] b_ramp;
        logic [4:0] mode;
        logic [4:0] pattern;
    } state_t;

    localparam state_t STATE_RESET = '{
        channel_power_down       : lane_power_pkg::RESET_CHANNEL_POWER_DOWN,
        extra_lane_enable_link_a : lane_power_pkg::RESET_EXTRA_LANE_ENABLE,
        extra_lane_enable_link_b : lane_power_pkg::RESET_EXTRA_LANE_ENABLE,
        rdata                    : lane_power_pkg::READ_UNMAPPED,
        rvalid                   : 1'b0,
        first_off                : 1'b0,
        second_off               : 1'b0,
        dig_first_off            : 1'b0,
        dig_second_off           : 1'b0,
        subsystem_off            : 1'b0,
        link_a_on                : 1'b0,
        link_b_on                : 1'b0,
        slots_undefined          : 1'b0,
        a_lane_clk               : 8'h00,
        a_ser_clk                : 8'h00,
        a_ramp                   : 8'h00,
        b_lane_clk               : 8'h00,
        b_ser_clk                : 8'h00,
        b_ramp                   : 8'h00,
        mode                     : 5'h00,
        pattern                  : 5'h00
    };

    state_t state;
    state_t next_state;

    // ------------------------------------------------------------------
    // derived controls
    // ------------------------------------------------------------------
    logic first_req_off;
    logic second_req_off;
    logic dig_first_off_c;
    logic dig_second_off_c;
    logic subsystem_off_c;
    logic link_a_on_c;
    logic link_b_on_c;
    logic slots_undefined_c;

    lane_ctrl_if link_a_if ();
    lane_ctrl_if link_b_if ();

    assign first_req_off  = state.channel_power_down[lane_power_pkg::FIRST_CHANNEL_OFF_BIT];
    assign second_req_off = state.channel_power_down[lane_power_pkg::SECOND_CHANNEL_OFF_BIT];

    channel_power_logic u_channel_power (
        .first_channel_off       (first_req_off),
        .second_channel_off      (second_req_off),
        .digital_channel_binding (digital_channel_binding),
        .mode_both_on_link_a     (mode_both_on_link_a),
        .serial_link_enable      (serial_link_enable),
        .digital_first_off       (dig_first_off_c),
        .digital_second_off      (dig_second_off_c),
        .subsystem_off           (subsystem_off_c),
        .link_a_on               (link_a_on_c),
        .link_b_on               (link_b_on_c),
        .second_slots_undefined  (slots_undefined_c)
    );

    // ------------------------------------------------------------------
    // lane control per link
    // ------------------------------------------------------------------
    assign link_a_if.extra_lane_reg = state.extra_lane_enable_link_a;
    assign link_a_if.mode_lanes     = mode_lanes_link_a;
    assign link_a_if.link_on        = link_a_on_c; // [RULE14]
    assign link_a_if.test_pattern   = test_pattern_select;

    // link B uses the same lane logic on its own register
    assign link_b_if.extra_lane_reg = state.extra_lane_enable_link_b; // [RULE16]
    assign link_b_if.mode_lanes     = mode_lanes_link_b;
    assign link_b_if.link_on        = link_b_on_c; // [RULE14]
    assign link_b_if.test_pattern   = test_pattern_select;

    lane_enable_logic u_lanes_a (
        .link (link_a_if.lanes)
    );

    lane_enable_logic u_lanes_b (
        .link (link_b_if.lanes)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;

        // register writes; unmapped addresses are ignored
        if (cfg_write) begin
            unique case (cfg_addr)
                lane_power_pkg::ADDR_CHANNEL_POWER_DOWN: begin
                    next_state.channel_power_down = cfg_wdata; // [RULE1] [RULE2]
                end
                lane_power_pkg::ADDR_EXTRA_LANE_ENABLE_LINK_A: begin
                    next_state.extra_lane_enable_link_a = cfg_wdata; // [RULE9] [RULE10]
                end
                lane_power_pkg::ADDR_EXTRA_LANE_ENABLE_LINK_B: begin
                    next_state.extra_lane_enable_link_b = cfg_wdata; // [RULE16]
                end
                default: begin
                end
            endcase
        end

        // register reads answer one cycle later
        next_state.rvalid = cfg_read;
        if (cfg_read) begin
            unique case (cfg_addr)
                lane_power_pkg::ADDR_CHANNEL_POWER_DOWN: begin
                    next_state.rdata = state.channel_power_down;
                end
                lane_power_pkg::ADDR_EXTRA_LANE_ENABLE_LINK_A: begin
                    next_state.rdata = state.extra_lane_enable_link_a;
                end
                lane_power_pkg::ADDR_EXTRA_LANE_ENABLE_LINK_B: begin
                    next_state.rdata = state.extra_lane_enable_link_b;
                end
                default: begin
                    next_state.rdata = lane_power_pkg::READ_UNMAPPED;
                end
            endcase
        end

        // converter power controls
        next_state.first_off       = first_req_off; // [RULE2]
        next_state.second_off      = second_req_off; // [RULE1]
        next_state.dig_first_off   = dig_first_off_c; // [RULE3]
        next_state.dig_second_off  = dig_second_off_c; // [RULE3]
        next_state.subsystem_off   = subsystem_off_c; // [RULE6]
        next_state.link_a_on       = link_a_on_c; // [RULE7]
        next_state.link_b_on       = link_b_on_c;
        next_state.slots_undefined = slots_undefined_c; // [RULE7]

        // lane controls
        next_state.a_lane_clk = link_a_if.lane_clk_en; // [RULE9]
        next_state.a_ser_clk  = link_a_if.ser_clk_en; // [RULE15]
        next_state.a_ramp     = link_a_if.lane_ramp; // [RULE13]
        next_state.b_lane_clk = link_b_if.lane_clk_en; // [RULE16]
        next_state.b_ser_clk  = link_b_if.ser_clk_en; // [RULE15]
        next_state.b_ramp     = link_b_if.lane_ramp; // [RULE13]

        // extra lanes run at the rate and mode of the whole link
        next_state.mode    = link_mode_select; // [RULE12]
        next_state.pattern = test_pattern_select; // [RULE12]
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign cfg_rdata              = state.rdata;
    assign cfg_rvalid             = state.rvalid;
    assign first_channel_off      = state.first_off;
    assign second_channel_off     = state.second_off;
    assign digital_first_off      = state.dig_first_off;
    assign digital_second_off     = state.dig_second_off;
    assign serial_subsystem_off   = state.subsystem_off;
    assign link_a_active          = state.link_a_on;
    assign link_b_active          = state.link_b_on;
    assign second_slots_undefined = state.slots_undefined;
    assign link_a_lane_clk_en     = state.a_lane_clk;
    assign link_a_ser_clk_en      = state.a_ser_clk;
    assign link_a_lane_ramp       = state.a_ramp;
    assign link_b_lane_clk_en     = state.b_lane_clk;
    assign link_b_ser_clk_en      = state.b_ser_clk;
    assign link_b_lane_ramp       = state.b_ramp;
    assign lane_mode              = state.mode;
    assign lane_test_pattern      = state.pattern;

endmodule : lane_channel_power_control

`default_nettype wire

// ===== lane_power_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------
// port relations of the power and lane control block
// ----------------
module lane_power_properties (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [11:0] cfg_addr,
    input wire logic [7:0]  cfg_wdata,
    input wire logic        cfg_write,
    input wire logic        cfg_read,
    input wire logic        cfg_rvalid,
    input wire logic        serial_link_enable,
    input wire logic [4:0]  link_mode_select,
    input wire logic [4:0]  test_pattern_select,
    input wire logic [1:0]  digital_channel_binding,
    input wire logic        mode_both_on_link_a,
    input wire logic [7:0]  mode_lanes_link_a,
    input wire logic        first_channel_off,
    input wire logic        second_channel_off,
    input wire logic        digital_first_off,
    input wire logic        digital_second_off,
    input wire logic        serial_subsystem_off,
    input wire logic        link_a_active,
    input wire logic        link_b_active,
    input wire logic        second_slots_undefined,
    input wire logic [7:0]  link_a_lane_clk_en,
    input wire logic [7:0]  link_a_ser_clk_en,
    input wire logic [7:0]  link_a_lane_ramp,
    input wire logic [4:0]  lane_mode
);
    // outputs lag inputs by one edge, register writes by two
    logic was_run;

    always_ff @(posedge ref_clk) begin
        was_run <= rst_n;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    read_answer_a: assert property (was_run |-> cfg_rvalid == $past(cfg_read))
        else $error("rvalid late");
    chan_off_a: assert property (
        cfg_write && cfg_addr == 12'h209 |-> ##2
        {6'h00, second_channel_off, first_channel_off} == ($past(cfg_wdata, 2) & 8'h03))
        else $error("off bits wrong");
    bind_follow_a: assert property (
        was_run |-> digital_first_off ==
        ($past(digital_channel_binding[0]) ? second_channel_off : first_channel_off)
        && digital_second_off ==
        ($past(digital_channel_binding[1]) ? first_channel_off : second_channel_off))
        else $error("binding ignored");
    subsys_off_a: assert property (
        serial_subsystem_off == (first_channel_off && second_channel_off))
        else $error("subsystem off wrong");
    link_b_on_a: assert property (
        was_run |-> link_b_active ==
        ($past(serial_link_enable) && !serial_subsystem_off && !digital_second_off))
        else $error("link b active wrong");
    shared_link_a: assert property (
        was_run && $past(mode_both_on_link_a) |->
        link_a_active == ($past(serial_link_enable) && !serial_subsystem_off)
        && second_slots_undefined == (link_a_active && digital_second_off))
        else $error("shared link wrong");
    lane_gate_a: assert property (
        !link_a_active |-> link_a_lane_clk_en == 8'h00 && link_a_ser_clk_en == 8'h00)
        else $error("lane on idle link");
    ser_chain_a: assert property (
        (link_a_ser_clk_en & ~{link_a_ser_clk_en[6:0], 1'b1}) == 8'h00
        && (link_a_ser_clk_en[7:1] & ~link_a_lane_clk_en[7:1]) == 7'h00)
        else $error("serializer chain broken");
    ramp_cause_a: assert property (
        was_run |-> (link_a_lane_ramp & ~(link_a_lane_clk_en & ~$past(mode_lanes_link_a))) == 8'h00
        && (link_a_lane_ramp == 8'h00 || $past(test_pattern_select) == 5'h00
        || $past(test_pattern_select) == 5'h05))
        else $error("stray ramp");
    mode_copy_a: assert property (was_run |-> lane_mode == $past(link_mode_select))
        else $error("lane mode wrong");
endmodule : lane_power_properties

bind lane_channel_power_control lane_power_properties u_props (.*);

`default_nettype wire

// ===== sw_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------
// software at the configuration port
// ----------------
module sw_host_model (
    input  wire logic        ref_clk,
    output logic      [11:0] cfg_addr,
    output logic      [7:0]  cfg_wdata,
    output logic             cfg_write,
    output logic             cfg_read,
    input  wire logic [7:0]  cfg_rdata,
    input  wire logic        cfg_rvalid,
    output logic             serial_link_enable
);
    logic link_wanted = 1'b0;

    initial begin
        cfg_addr = 12'h000;
        cfg_wdata = 8'h00;
        cfg_write = 1'b0;
        cfg_read = 1'b0;
        serial_link_enable = 1'b0;
    end

    task automatic set_link(input logic on);
        @(posedge ref_clk);
        link_wanted = on;
        serial_link_enable <= on;
    endtask : set_link

    // mode and calibration registers are not on this port
    // link is dropped around every write
    task automatic write_reg(input logic [11:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        serial_link_enable <= 1'b0;
        @(posedge ref_clk);
        cfg_addr <= addr;
        cfg_wdata <= data;
        cfg_write <= 1'b1;
        @(posedge ref_clk);
        cfg_write <= 1'b0;
        cfg_addr <= ~addr;
        cfg_wdata <= ~data;
        serial_link_enable <= link_wanted;
    endtask : write_reg

    task automatic read_reg(input logic [11:0] addr, output logic [7:0] data, output logic ok);
        ok = 1'b0;
        data = 8'h00;
        @(posedge ref_clk);
        cfg_addr <= addr;
        cfg_read <= 1'b1;
        @(posedge ref_clk);
        cfg_read <= 1'b0;
        cfg_addr <= ~addr;
        #1;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (cfg_rvalid === 1'b1) begin
                data = cfg_rdata;
                ok = 1'b1;
            end else begin
                @(posedge ref_clk);
                #1;
            end
        end
    endtask : read_reg
endmodule : sw_host_model

`default_nettype wire

// ===== lane_channel_power_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

module lane_channel_power_control_bench;
    logic        ref_clk = 1'b0, rst_n = 1'b0, cfg_write, cfg_read, cfg_rvalid;
    logic        serial_link_enable, mode_both_on_link_a = 1'b0;
    logic [11:0] cfg_addr;
    logic [7:0]  cfg_wdata, cfg_rdata, mode_lanes_link_a = 8'h00, mode_lanes_link_b = 8'h00;
    logic [4:0]  link_mode_select = 5'h00, test_pattern_select = 5'h00;
    logic [4:0]  lane_mode, lane_test_pattern;
    logic [1:0]  digital_channel_binding = 2'h0;
    logic        first_channel_off, second_channel_off, digital_first_off, digital_second_off;
    logic        serial_subsystem_off, link_a_active, link_b_active, second_slots_undefined;
    logic [7:0]  link_a_lane_clk_en, link_a_ser_clk_en, link_a_lane_ramp;
    logic [7:0]  link_b_lane_clk_en, link_b_ser_clk_en, link_b_lane_ramp;
    int          num_errors = 0, comparisons = 0;

    wire logic [7:0]  pwr = {first_channel_off, second_channel_off, digital_first_off,
        digital_second_off, serial_subsystem_off, link_a_active, link_b_active,
        second_slots_undefined};
    wire logic [23:0] lanes_a = {link_a_lane_clk_en, link_a_ser_clk_en, link_a_lane_ramp};
    wire logic [23:0] lanes_b = {link_b_lane_clk_en, link_b_ser_clk_en, link_b_lane_ramp};
    // extra, mode lanes, pattern, lane clocks, serializers, ramp
    logic [47:0] lane_case [5] = '{48'hF10F00FFFFF0, 48'hF00F05FF0FF0, 48'hF10F04FFFF00,
        48'h1903001B0318, 48'hFE0101FF0100};
    logic [11:0] regs [4] = '{12'h209, 12'h20A, 12'h20B, 12'h20C};

    always #5 ref_clk = ~ref_clk;

    sw_host_model u_host (.*);

    lane_channel_power_control u_dut (.*);

    // ----------------
    // checking and closing
    // ----------------
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic check_rd(input logic [11:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_host.read_reg(addr, d, ok);
        comparisons++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("ERROR at %0t read answer missing %h", $time, addr);
            close_out();
        end
        if (d !== exp) begin
            num_errors++;
            $display("ERROR at %0t read %h expected %h", $time, d, exp);
        end
    endtask : check_rd

    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : settle

    // ----------------
    // main sequence
    // ----------------
    initial begin
        logic        fo, so, dfo, dso, la, lb;
        logic [47:0] lc;
        repeat (20) @(posedge ref_clk);
        #1;
        check({16'h0, pwr}, 24'h000000);
        check(lanes_a, 24'h000000);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        u_host.set_link(1'b1);
        for (int i = 0; i < 4; i++) check_rd(regs[i], 8'h00);
        for (int i = 0; i < 4; i++) u_host.write_reg(regs[i], 8'hA5);
        for (int i = 0; i < 4; i++) check_rd(regs[i], (i < 3) ? 8'hA5 : 8'h00);
        $display("test registers done");

        for (int p = 0; p < 32; p++) begin
            u_host.write_reg(12'h209, {6'h00, p[1:0]});
            @(posedge ref_clk);
            digital_channel_binding <= p[3:2];
            mode_both_on_link_a <= p[4];
            settle();
            fo = p[0];
            so = p[1];
            dfo = p[2] ? so : fo;
            dso = p[3] ? fo : so;
            la = !(fo && so) && (!dfo || p[4]);
            lb = !(fo && so) && !dso;
            check({16'h0, pwr}, {16'h0, fo, so, dfo, dso, fo && so, la, lb, la && p[4] && dso});
        end
        $display("test channel power done");

        u_host.write_reg(12'h209, 8'h00);
        @(posedge ref_clk);
        digital_channel_binding <= 2'h0;
        mode_both_on_link_a <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            lc = lane_case[k];
            u_host.write_reg(12'h20A, lc[47:40]);
            u_host.write_reg(12'h20B, lc[47:40]);
            @(posedge ref_clk);
            mode_lanes_link_a <= lc[39:32];
            mode_lanes_link_b <= lc[39:32];
            test_pattern_select <= lc[28:24];
            link_mode_select <= 5'(k);
            settle();
            check(lanes_a, lc[23:0]);
            check(lanes_b, lc[23:0]);
            check({9'h0, lane_test_pattern, 5'h0, lane_mode}, {9'h0, lc[28:24], 5'h0, 5'(k)});
        end
        $display("test extra lanes done");

        u_host.write_reg(12'h209, 8'h01);
        settle();
        check(lanes_a, 24'h000000);
        check(lanes_b, 24'hFF0100);
        $display("test power override done");
        close_out();
    end
endmodule : lane_channel_power_control_bench

`default_nettype wire
